// ===== pmwc_pkg.sv
// Types shared by the power-mode and wake control block.
package pmwc_pkg;
   typedef enum logic [1:0] {PMWC_RUN, PMWC_SLEEP, PMWC_IDLE} pmwc_mode_t;
endpackage

// ===== pmwc_regs.svh
// Register offsets, field positions, masks, reset values and AXI responses for pmwc.
`ifndef PMWC_REGS_SVH
`define PMWC_REGS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define PMWC_CORE_STATUS_OFS 8'h00
`define PMWC_WAKE_EN_OFS 8'h04
`define PMWC_CPU_CTRL_OFS 8'h08
`define PMWC_EVENT_OFS 8'h0C
`define PMWC_MODE_OFS 8'h10

// ************************************************************
// Field positions
// ************************************************************
`define PMWC_TIMEOUT_BIT 4
`define PMWC_PWRDOWN_BIT 3
`define PMWC_PIN_WAKE_BIT 6
`define PMWC_CONV_WAKE_BIT 5
`define PMWC_EXT_WAKE_BIT 4
`define PMWC_TIMER_SEL_BIT 6
`define PMWC_CORE_SEL_BIT 5
`define PMWC_IDLE_EN_BIT 4
`define PMWC_EV_SLEEP_BIT 0
`define PMWC_EV_WDCLR_BIT 1

// ************************************************************
// Writable and status-read masks and reset values
// ************************************************************
`define PMWC_WAKE_EN_MASK 8'h70
`define PMWC_CPU_CTRL_MASK 8'h70
`define PMWC_STATUS_LOW_MASK 8'h07
`define PMWC_WAKE_EN_RST 8'h00
`define PMWC_CPU_CTRL_RST 8'h60
`define PMWC_STATUS_RST 8'h18

// ************************************************************
// AXI responses
// ************************************************************
`define PMWC_RESP_OKAY 2'h0
`define PMWC_RESP_SLVERR 2'h2

`endif

// ===== pmwc_top.sv
// Power-mode, wake-up and clock-select control with an AXI4-Lite slave.
// ************************************************************
// What this block does
// - Time-out flag: set by sleep/clear/power-up, cleared by timeout.
// - Power-down flag: set power-on/clear, cleared by sleep.
// - Status top three bits read zero.
// - Wake bit 6 enables port-6 change wake.
// - Wake bit 5 enables conversion-done wake.
// - Wake bit 4 enables external pin wake.
// - Wake bit 7 and low four read zero.
// - Control bit 6 picks timer clock source.
// - Control bit 5 picks core clock source.
// - Core select zero stops the main oscillator.
// - Sleep instruction enters idle if bit 4 set.
// ************************************************************
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`include "pmwc_regs.svh"

module pmwc_top (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_instruction,
   input wire logic watchdog_clear_instruction,
   input wire logic watchdog_timeout,
   input wire logic [7:0] status_low_bits,
   input wire logic port6_change,
   input wire logic conv_done,
   input wire logic ext_pin_event,
   output logic timer_clock_sel,
   output logic core_clock_sel,
   output logic main_osc_en,
   output logic sub_osc_en,
   output logic cpu_clk_en,
   output logic sleeping,
   output logic idling,
   output logic wake_pulse
);

   // ************************************************************
   // Register state
   // ************************************************************
   logic timeout_flag;
   logic pwrdown_flag;
   logic [7:0] wake_source_enable;
   logic [7:0] cpu_operating_control;
   pmwc_pkg::pmwc_mode_t mode;
   pmwc_pkg::pmwc_mode_t next_mode;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic sw_sleep;
   logic sw_wdclr;
   logic any_sleep;
   logic any_wdclr;
   logic wake_hit;
   logic pin_change_wake_en;
   logic conv_done_wake_en;
   logic ext_pin_wake_en;
   logic idle_en;

   function automatic logic pmwc_mapped(input logic [7:0] a);
      pmwc_mapped = (a == `PMWC_CORE_STATUS_OFS) ||
         (a == `PMWC_WAKE_EN_OFS) || (a == `PMWC_CPU_CTRL_OFS) ||
         (a == `PMWC_EVENT_OFS) || (a == `PMWC_MODE_OFS);
   endfunction

   function automatic logic [7:0] pmwc_status(input logic t,
                                              input logic p,
                                              input logic [7:0] low);
      logic [7:0] v;
      v = low & `PMWC_STATUS_LOW_MASK;
      v[`PMWC_TIMEOUT_BIT] = t;
      v[`PMWC_PWRDOWN_BIT] = p;
      pmwc_status = v;
   endfunction

   assign pin_change_wake_en = wake_source_enable[`PMWC_PIN_WAKE_BIT];
   assign conv_done_wake_en = wake_source_enable[`PMWC_CONV_WAKE_BIT];
   assign ext_pin_wake_en = wake_source_enable[`PMWC_EXT_WAKE_BIT];
   assign idle_en = cpu_operating_control[`PMWC_IDLE_EN_BIT];

   // ************************************************************
   // AXI4-Lite write channel
   // ************************************************************
   // Address and data are latched independently, so either order works.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMWC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= pmwc_mapped(aw_addr) ? `PMWC_RESP_OKAY :
                           `PMWC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Writing the event register lets software issue the instructions.
   assign sw_sleep = do_write && w_strb[0] &&
      (aw_addr == `PMWC_EVENT_OFS) && w_data[`PMWC_EV_SLEEP_BIT];
   assign sw_wdclr = do_write && w_strb[0] &&
      (aw_addr == `PMWC_EVENT_OFS) && w_data[`PMWC_EV_WDCLR_BIT];
   assign any_sleep = sleep_instruction || sw_sleep;
   assign any_wdclr = watchdog_clear_instruction || sw_wdclr;

   // ************************************************************
   // Control registers
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wake_source_enable <= `PMWC_WAKE_EN_RST;
      end else if (do_write && w_strb[0] &&
                   aw_addr == `PMWC_WAKE_EN_OFS) begin
         wake_source_enable <= w_data[7:0] & `PMWC_WAKE_EN_MASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpu_operating_control <= `PMWC_CPU_CTRL_RST;
      end else if (do_write && w_strb[0] &&
                   aw_addr == `PMWC_CPU_CTRL_OFS) begin
         cpu_operating_control <= w_data[7:0] & `PMWC_CPU_CTRL_MASK;
      end
   end

   // ************************************************************
   // Status flags
   // ************************************************************
   // A watchdog time-out in the same cycle as a setting event wins,
   // because the time-out is the event that software must observe.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timeout_flag <= 1'b1;
      end else if (watchdog_timeout) begin
         timeout_flag <= 1'b0;
      end else if (any_sleep || any_wdclr) begin
         timeout_flag <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pwrdown_flag <= 1'b1;
      end else if (any_wdclr) begin
         pwrdown_flag <= 1'b1;
      end else if (any_sleep) begin
         pwrdown_flag <= 1'b0;
      end
   end

   // ************************************************************
   // Power mode
   // ************************************************************
   assign wake_hit = (pin_change_wake_en && port6_change) ||
                     (conv_done_wake_en && conv_done) ||
                     (ext_pin_wake_en && ext_pin_event);

   always_comb begin
      next_mode = mode;
      unique case (mode)
         pmwc_pkg::PMWC_RUN: begin
            if (any_sleep) begin
               next_mode = idle_en ? pmwc_pkg::PMWC_IDLE :
                           pmwc_pkg::PMWC_SLEEP;
            end
         end
         pmwc_pkg::PMWC_SLEEP, pmwc_pkg::PMWC_IDLE: begin
            if (wake_hit) begin
               next_mode = pmwc_pkg::PMWC_RUN;
            end
         end
         default: next_mode = pmwc_pkg::PMWC_RUN;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode <= pmwc_pkg::PMWC_RUN;
         wake_pulse <= 1'b0;
      end else begin
         mode <= next_mode;
         wake_pulse <= (mode != pmwc_pkg::PMWC_RUN) && wake_hit;
      end
   end

   // ************************************************************
   // Clock enables
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timer_clock_sel <= 1'b1;
         core_clock_sel <= 1'b1;
         main_osc_en <= 1'b1;
         sub_osc_en <= 1'b1;
         cpu_clk_en <= 1'b1;
         sleeping <= 1'b0;
         idling <= 1'b0;
      end else begin
         timer_clock_sel <= cpu_operating_control[`PMWC_TIMER_SEL_BIT];
         core_clock_sel <= cpu_operating_control[`PMWC_CORE_SEL_BIT];
         main_osc_en <= (next_mode == pmwc_pkg::PMWC_RUN) &&
            cpu_operating_control[`PMWC_CORE_SEL_BIT];
         sub_osc_en <= next_mode != pmwc_pkg::PMWC_SLEEP;
         cpu_clk_en <= next_mode == pmwc_pkg::PMWC_RUN;
         sleeping <= next_mode == pmwc_pkg::PMWC_SLEEP;
         idling <= next_mode == pmwc_pkg::PMWC_IDLE;
      end
   end

   // ************************************************************
   // AXI4-Lite read channel
   // ************************************************************
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PMWC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= pmwc_mapped(s_axi_araddr) ? `PMWC_RESP_OKAY :
                        `PMWC_RESP_SLVERR;
         unique case (s_axi_araddr)
            `PMWC_CORE_STATUS_OFS: s_axi_rdata <= {24'h000000,
               pmwc_status(timeout_flag, pwrdown_flag, status_low_bits)};
            `PMWC_WAKE_EN_OFS: s_axi_rdata <= {24'h000000,
               wake_source_enable};
            `PMWC_CPU_CTRL_OFS: s_axi_rdata <= {24'h000000,
               cpu_operating_control};
            `PMWC_MODE_OFS: s_axi_rdata <= {30'h00000000, mode};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   status_top_zero_a: assert property (@(posedge core_clk) disable iff (rst)
      pmwc_status(timeout_flag, pwrdown_flag, status_low_bits)[7:5] == 3'h0)
      else $error("status top bits not zero");
   timeout_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      watchdog_timeout |=> !timeout_flag)
      else $error("timeout flag not cleared");
   timeout_set_a: assert property (@(posedge core_clk) disable iff (rst)
      (any_sleep || any_wdclr) && !watchdog_timeout |=> timeout_flag)
      else $error("timeout flag not set");
   pwrdown_sleep_a: assert property (@(posedge core_clk) disable iff (rst)
      any_sleep && !any_wdclr |=> !pwrdown_flag)
      else $error("power-down flag not cleared");
   wake_reserved_a: assert property (@(posedge core_clk) disable iff (rst)
      (wake_source_enable & ~`PMWC_WAKE_EN_MASK) == 8'h00)
      else $error("wake reserved bits set");
   sleep_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      mode == pmwc_pkg::PMWC_RUN && any_sleep |=> ##1
      (sleeping == !$past(idle_en, 2)) && !cpu_clk_en)
      else $error("wrong low-power mode");
   main_osc_stop_a: assert property (@(posedge core_clk) disable iff (rst)
      !cpu_operating_control[`PMWC_CORE_SEL_BIT] |=> !main_osc_en)
      else $error("main oscillator running");
   wake_exit_a: assert property (@(posedge core_clk) disable iff (rst)
      mode != pmwc_pkg::PMWC_RUN && wake_hit |=> wake_pulse ##0 cpu_clk_en)
      else $error("wake did not resume");
   idle_sub_osc_a: assert property (@(posedge core_clk) disable iff (rst)
      idling |-> sub_osc_en && !main_osc_en)
      else $error("idle oscillator state wrong");
   timer_sel_a: assert property (@(posedge core_clk) disable iff (rst)
      timer_clock_sel == $past(cpu_operating_control[`PMWC_TIMER_SEL_BIT]))
      else $error("timer clock select lags");
   core_sel_a: assert property (@(posedge core_clk) disable iff (rst)
      core_clock_sel == $past(cpu_operating_control[`PMWC_CORE_SEL_BIT]))
      else $error("core clock select lags");
   ctrl_reserved_a: assert property (@(posedge core_clk) disable iff (rst)
      (cpu_operating_control & ~`PMWC_CPU_CTRL_MASK) == 8'h00)
      else $error("control reserved bits set");
   pwrdown_set_a: assert property (@(posedge core_clk) disable iff (rst)
      any_wdclr |=> pwrdown_flag)
      else $error("power-down flag not set");
   idle_entry_a: assert property (@(posedge core_clk) disable iff (rst)
      mode == pmwc_pkg::PMWC_RUN && any_sleep && idle_en |=> idling)
      else $error("idle mode not entered");
   sleep_osc_a: assert property (@(posedge core_clk) disable iff (rst)
      sleeping |-> !sub_osc_en && !main_osc_en && !cpu_clk_en)
      else $error("sleep oscillator state wrong");
   // A disabled source must never pulse, or the core would resume early.
   wake_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      mode != pmwc_pkg::PMWC_RUN && !wake_hit |=> !wake_pulse)
      else $error("wake without enabled source");
   rdata_upper_a: assert property (@(posedge core_clk) disable iff (rst)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");

endmodule

// ===== pmwc_top_test.sv
// Self-checking bench for the power-mode and wake control block.
`include "pmwc_regs.svh"
`define TB_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
$display("mismatch %s exp %h got %h", nm, e, g); end end

module pmwc_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************************************
   // Signals
   // ************************************************************
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h1;
   logic [7:0] low = 8'h00;
   logic [5:0] ev = 6'h00;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic tsel, csel, mosc, sosc, cpuen, slp, idl, wk;
   int fails = 0;
   int compares = 0;
   logic t = 1'b1;
   logic p = 1'b1;
   logic [1:0] rs;
   logic [31:0] v;
   logic [7:0] d;
   logic [7:0] c;

   pmwc_top DUT (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sleep_instruction(ev[5]),
      .watchdog_clear_instruction(ev[4]), .watchdog_timeout(ev[3]),
      .status_low_bits(low), .port6_change(ev[2]), .conv_done(ev[1]),
      .ext_pin_event(ev[0]), .timer_clock_sel(tsel), .core_clock_sel(csel),
      .main_osc_en(mosc), .sub_osc_en(sosc), .cpu_clk_en(cpuen),
      .sleeping(slp), .idling(idl), .wake_pulse(wk));

   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task wrap_up;
      begin
         if (fails == 0 && compares > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask

   task hang;
      begin
         fails++;
         wrap_up();
      end
   endtask

   // Valid and payload are held until the edge that samples ready high.
   task wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] r);
      int n;
      begin
         n = 0;
         @(posedge core_clk);
         awaddr <= a;
         wdata <= dt;
         wstrb <= 4'h1 | 4'($urandom);
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         forever begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
            n++;
            if (n > 50) hang();
         end
         r = bresp;
         bready <= 1'b0;
      end
   endtask

   task rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] r);
      int n;
      begin
         n = 0;
         @(posedge core_clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         forever begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
            n++;
            if (n > 50) hang();
         end
         dt = rdata;
         r = rresp;
         rready <= 1'b0;
      end
   endtask

   task chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] x;
      logic [1:0] r;
      begin
         rd(a, x, r);
         `TB_CHK(nm, e, x)
         `TB_CHK("rresp", `PMWC_RESP_OKAY, r)
      end
   endtask

   task pulse(input int b);
      begin
         @(posedge core_clk);
         ev[b] <= 1'b1;
         @(posedge core_clk);
         ev <= 6'h00;
         #1;
      end
   endtask

   function logic [31:0] stat_exp();
      return {27'h0, t, p, low[2:0]};
   endfunction

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      void'($urandom(89743));
      low = 8'($urandom);
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      `TB_CHK("outs", 8'hF8, {tsel, csel, mosc, sosc, cpuen, slp, idl, wk})
      chk_rd(`PMWC_CORE_STATUS_OFS, stat_exp(), "status");
      chk_rd(`PMWC_WAKE_EN_OFS, 32'h0, "wake");
      chk_rd(`PMWC_CPU_CTRL_OFS, 32'h60, "ctrl");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         if (i == 0) d = 8'hFF;
         if (i == 1) d = 8'h00;
         wr(`PMWC_WAKE_EN_OFS, {24'($urandom), d}, rs);
         `TB_CHK("bresp", `PMWC_RESP_OKAY, rs)
         chk_rd(`PMWC_WAKE_EN_OFS, {24'h0, d & 8'h70}, "wake");
         wr(`PMWC_CPU_CTRL_OFS, {24'h0, d}, rs);
         chk_rd(`PMWC_CPU_CTRL_OFS, {24'h0, d & 8'h70}, "ctrl");
         `TB_CHK("sel", {d[6], d[5], d[5]}, {tsel, csel, mosc})
      end
      // Unmapped offsets answer with an error and read as zero.
      wr(8'h20, 32'hFF, rs);
      `TB_CHK("bresp bad", `PMWC_RESP_SLVERR, rs)
      rd(8'h20, v, rs);
      `TB_CHK("rresp bad", `PMWC_RESP_SLVERR, rs)
      `TB_CHK("rdata bad", 32'h0, v)
      low <= 8'($urandom);
      pulse(3);
      t = 1'b0;
      chk_rd(`PMWC_CORE_STATUS_OFS, stat_exp(), "status");
      for (int i = 0; i < 3; i++) begin
         c = (i == 1) ? 8'h70 : ((i == 2) ? 8'h40 : 8'h60);
         wr(`PMWC_WAKE_EN_OFS, {24'h0, 8'h10 << i}, rs);
         wr(`PMWC_CPU_CTRL_OFS, {24'h0, c}, rs);
         pulse(5);
         t = 1'b1;
         p = 1'b0;
         `TB_CHK("asleep", {c[4], !c[4], 2'b00, c[4]}, {idl, slp, cpuen, mosc, sosc})
         chk_rd(`PMWC_MODE_OFS, c[4] ? 32'h2 : 32'h1, "mode");
         chk_rd(`PMWC_CORE_STATUS_OFS, stat_exp(), "status");
         pulse((i + 1) % 3);
         `TB_CHK("no wake", 3'b100, {slp | idl, cpuen, wk})
         pulse(i);
         `TB_CHK("wake", {4'b1100, c[5]}, {wk, cpuen, slp, idl, mosc})
         @(posedge core_clk);
         #1;
         `TB_CHK("wake end", 1'b0, wk)
      end
      wr(`PMWC_EVENT_OFS, 32'h2, rs);
      t = 1'b1;
      p = 1'b1;
      chk_rd(`PMWC_CORE_STATUS_OFS, stat_exp(), "status");
      pulse(3);
      t = 1'b0;
      chk_rd(`PMWC_CORE_STATUS_OFS, stat_exp(), "status");
      pulse(4);
      t = 1'b1;
      chk_rd(`PMWC_CORE_STATUS_OFS, stat_exp(), "status");
      wrap_up();
   end
endmodule
